// ===== core/ocs_top.sv
// Oscillator reference clock selection with stop-mode gating and AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ocs_top #(
  parameter int ADDR_W = ocs_pkg::OCS_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Oscillator and pin side
  input wire logic i_internal_osc_clock,
  input wire logic i_rc_osc_clock,
  input wire logic i_crystal_osc_clock,
  input wire logic i_crystal_amp_out,
  input wire logic i_bus_clock,
  input wire logic [7:0] i_mask_option_word,
  input wire logic i_stop_mode,
  output logic o_internal_osc_enable,
  output logic o_rc_osc_enable,
  output logic o_crystal_osc_enable,
  output logic o_main_reference_clock,
  output logic o_pll_reference_clock,
  output logic o_timebase_reference_clock,
  output logic o_osc_output_pin,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  // Synchronised oscillator levels and pins
  logic [4:0] pins_sync;
  logic int_osc_s; // Internal oscillator level
  logic rc_osc_s; // RC oscillator level
  logic xtal_osc_s; // Crystal oscillator level
  logic xamp_s; // Crystal amplifier output level
  logic bus_s; // Bus clock level

  // Option word and configuration state
  logic [7:0] mask_option_word; // Captured after reset release
  logic mow_loaded; // Option word captured since last reset
  logic [ocs_pkg::OCS_CFG_W-1:0] config_word_two; // Software written config
  ocs_pkg::ocs_main_sel_e main_sel; // Decoded main select
  ocs_pkg::ocs_tb_sel_e tb_sel; // Decoded timebase select

  // Enables and selected clocks
  logic next_int_en;
  logic next_rc_en;
  logic next_xtal_en;
  logic next_main;
  logic next_tb;
  logic next_pin_out; // Oscillator output pin level

  // Bus slave state
  logic aw_held; // Write address captured
  logic w_held; // Write data captured
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_rdata;
  logic next_rerr;

  // Oscillator levels arrive from another timing domain, so synchronise them
  ocs_sync #(
    .WIDTH(5)
  ) ocs_sync_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_bus_clock, i_crystal_amp_out, i_crystal_osc_clock, i_rc_osc_clock, i_internal_osc_clock}),
    .o_sync(pins_sync)
  );

  assign int_osc_s = pins_sync[0];
  assign rc_osc_s = pins_sync[1];
  assign xtal_osc_s = pins_sync[2];
  assign xamp_s = pins_sync[3];
  assign bus_s = pins_sync[4];

  // Capture the option word once after reset; it is static afterwards, not writable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_option_word <= 8'h00;
      mow_loaded <= 1'b0;
    end else if (!mow_loaded) begin
      mask_option_word <= i_mask_option_word;
      mow_loaded <= 1'b1;
    end
  end

  // Field decode of both select words
  assign main_sel = ocs_pkg::ocs_main_sel_e'(
    mask_option_word[ocs_pkg::OCS_MOW_SEL_HI:ocs_pkg::OCS_MOW_SEL_LO]);
  assign tb_sel = ocs_pkg::ocs_tb_sel_e'(
    config_word_two[ocs_pkg::OCS_CFG_TB_SEL_HI:ocs_pkg::OCS_CFG_TB_SEL_LO]);

  // Oscillator enables; RC and crystal are mutually exclusive by construction
  always_comb begin
    // Internal oscillator ignores main choice; only stop with the disable bit halts it
    next_int_en = !(i_stop_mode && config_word_two[ocs_pkg::OCS_CFG_STOP_INT_DIS]);
    next_rc_en = (main_sel == ocs_pkg::OCS_MAIN_RC) &&
                 (!i_stop_mode || config_word_two[ocs_pkg::OCS_CFG_STOP_RC_KEEP]);
    next_xtal_en = (main_sel == ocs_pkg::OCS_MAIN_XTAL) &&
                   (!i_stop_mode || config_word_two[ocs_pkg::OCS_CFG_STOP_XTAL_KEEP]);
  end

  // Main reference and output pin mux
  always_comb begin
    case (main_sel)
      ocs_pkg::OCS_MAIN_INT: begin
        next_main = int_osc_s && next_int_en;
        next_pin_out = bus_s;
      end
      ocs_pkg::OCS_MAIN_RC: begin
        next_main = rc_osc_s && next_rc_en;
        next_pin_out = bus_s;
      end
      ocs_pkg::OCS_MAIN_XTAL: begin
        next_main = xtal_osc_s && next_xtal_en;
        next_pin_out = xamp_s;
      end
      default: begin
        // Unused encoding passes nothing through
        next_main = 1'b0;
        next_pin_out = 1'b0;
      end
    endcase
  end

  // Timebase mux; RC or crystal only usable when also the main choice
  always_comb begin
    case (tb_sel)
      ocs_pkg::OCS_TB_INT: next_tb = int_osc_s && next_int_en;
      ocs_pkg::OCS_TB_RC: next_tb = rc_osc_s && next_rc_en;
      ocs_pkg::OCS_TB_XTAL: next_tb = xtal_osc_s && next_xtal_en;
      default: next_tb = 1'b0; // Unused encoding
    endcase
  end

  // Registered clock and enable outputs; one cycle of latency after the synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_internal_osc_enable <= 1'b1;
      o_rc_osc_enable <= 1'b0;
      o_crystal_osc_enable <= 1'b0;
      o_main_reference_clock <= 1'b0;
      o_pll_reference_clock <= 1'b0;
      o_timebase_reference_clock <= 1'b0;
      o_osc_output_pin <= 1'b0;
    end else begin
      o_internal_osc_enable <= next_int_en;
      // Option word not yet captured: keep external oscillators off
      o_rc_osc_enable <= next_rc_en && mow_loaded;
      o_crystal_osc_enable <= next_xtal_en && mow_loaded;
      o_main_reference_clock <= next_main;
      o_pll_reference_clock <= next_main;
      o_timebase_reference_clock <= next_tb;
      o_osc_output_pin <= next_pin_out;
    end
  end

  // Write channel acceptance; address and data may arrive in either order
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;

  // Latch address and data, then perform the write when both are held
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= ocs_pkg::OCS_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        // Option word and status are read only: writes are dropped but answered
        if (aw_addr == ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO || aw_addr == ocs_pkg::OCS_ADDR_MASK_OPTION_WORD ||
            aw_addr == ocs_pkg::OCS_ADDR_STATUS) begin
          o_s_axi_bresp <= ocs_pkg::OCS_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= ocs_pkg::OCS_RESP_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Config word two update; only the low byte lane carries fields
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      config_word_two <= ocs_pkg::OCS_CFG_RESET;
    end else if (aw_held && w_held && aw_addr == ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO && w_strb[0]) begin
      config_word_two <= w_data[ocs_pkg::OCS_CFG_W-1:0];
    end
  end

  // Read decode; unused upper bits read as zero
  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (i_s_axi_araddr)
      ocs_pkg::OCS_ADDR_MASK_OPTION_WORD: next_rdata[7:0] = mask_option_word;
      ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO: next_rdata[ocs_pkg::OCS_CFG_W-1:0] = config_word_two;
      ocs_pkg::OCS_ADDR_STATUS: begin
        next_rdata[ocs_pkg::OCS_ST_INT_EN] = o_internal_osc_enable;
        next_rdata[ocs_pkg::OCS_ST_RC_EN] = o_rc_osc_enable;
        next_rdata[ocs_pkg::OCS_ST_XTAL_EN] = o_crystal_osc_enable;
        next_rdata[ocs_pkg::OCS_ST_STOP] = i_stop_mode;
      end
      default: next_rerr = 1'b1; // Unmapped address
    endcase
  end

  // Read channel: one read in flight, answered the cycle after acceptance
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= ocs_pkg::OCS_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= next_rdata;
      o_s_axi_rresp <= next_rerr ? ocs_pkg::OCS_RESP_SLVERR : ocs_pkg::OCS_RESP_OKAY;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== core/ocs_pkg.sv
// Package with register map, field layout and encodings for the oscillator clock select block
package ocs_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] OCS_IDX_MASK_OPTION_WORD = 16'hffcf;
  localparam logic [15:0] OCS_IDX_CONFIG_WORD_TWO = 16'h001d;
  localparam logic [15:0] OCS_IDX_STATUS = 16'h001e;
  localparam int OCS_ADDR_W = 18;
  localparam logic [OCS_ADDR_W-1:0] OCS_ADDR_MASK_OPTION_WORD = {OCS_IDX_MASK_OPTION_WORD, 2'b00};
  localparam logic [OCS_ADDR_W-1:0] OCS_ADDR_CONFIG_WORD_TWO = {OCS_IDX_CONFIG_WORD_TWO, 2'b00};
  localparam logic [OCS_ADDR_W-1:0] OCS_ADDR_STATUS = {OCS_IDX_STATUS, 2'b00};

  // Mask option word: main reference select field
  localparam int OCS_MOW_SEL_LO = 0;
  localparam int OCS_MOW_SEL_HI = 1;

  // Config word two field positions
  localparam int OCS_CFG_TB_SEL_LO = 0;
  localparam int OCS_CFG_TB_SEL_HI = 1;
  localparam int OCS_CFG_STOP_INT_DIS = 2;
  localparam int OCS_CFG_STOP_XTAL_KEEP = 3;
  localparam int OCS_CFG_STOP_RC_KEEP = 4;
  localparam int OCS_CFG_W = 5;
  localparam logic [OCS_CFG_W-1:0] OCS_CFG_RESET = 5'h00;

  // Status word field positions
  localparam int OCS_ST_INT_EN = 0;
  localparam int OCS_ST_RC_EN = 1;
  localparam int OCS_ST_XTAL_EN = 2;
  localparam int OCS_ST_STOP = 3;
  localparam int OCS_ST_W = 4;

  // Bus response codes
  localparam logic [1:0] OCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCS_RESP_SLVERR = 2'h2;

  // Main reference select encodings
  typedef enum logic [1:0] {
    OCS_MAIN_UNUSED = 2'b00,
    OCS_MAIN_INT = 2'b01,
    OCS_MAIN_RC = 2'b10,
    OCS_MAIN_XTAL = 2'b11
  } ocs_main_sel_e;

  // Timebase reference select encodings
  typedef enum logic [1:0] {
    OCS_TB_INT = 2'b00,
    OCS_TB_RC = 2'b01,
    OCS_TB_XTAL = 2'b10,
    OCS_TB_UNUSED = 2'b11
  } ocs_tb_sel_e;

endpackage

// ===== core/ocs_sync.sv
// Two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ocs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta; // First stage, read only by the second stage

  // Two stages; only the second one is visible to other logic
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/ocs_checker.sv
// Port assertions for the oscillator clock select block
`timescale 1ns/1ps
`default_nettype none
module ocs_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_internal_osc_clock,
  input wire logic i_rc_osc_clock,
  input wire logic i_crystal_osc_clock,
  input wire logic i_crystal_amp_out,
  input wire logic i_bus_clock,
  input wire logic [7:0] i_mask_option_word,
  input wire logic i_stop_mode,
  input wire logic o_internal_osc_enable,
  input wire logic o_rc_osc_enable,
  input wire logic o_crystal_osc_enable,
  input wire logic o_main_reference_clock,
  input wire logic o_pll_reference_clock,
  input wire logic o_osc_output_pin
);
  logic loaded; // Option word already captured
  logic [1:0] sel; // Captured main select
  logic [2:0] quiet; // Cycles since reset or stop, saturating
  logic sel_clk; // Oscillator named by the captured select
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // One-time capture, since the option word is static after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) loaded <= 1'b0;
    else if (!loaded) {loaded, sel} <= {1'b1, i_mask_option_word[1:0]};
  end
  // Clock paths pass two sync stages and the output register, so they are judged only once settled
  always_ff @(posedge i_clk) quiet <= (i_rst || i_stop_mode) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  assign sel_clk = sel[1] ? (sel[0] ? i_crystal_osc_clock : i_rc_osc_clock) : sel[0] & i_internal_osc_clock;
  pll_copy_a: assert property (o_pll_reference_clock == o_main_reference_clock) else $error("pll copy");
  osc_excl_a: assert property (!(o_rc_osc_enable && o_crystal_osc_enable)) else $error("both on");
  int_reset_a: assert property ($fell(i_rst) |-> o_internal_osc_enable) else $error("int off");
  int_runs_a: assert property (!i_stop_mode |=> o_internal_osc_enable) else $error("int stop");
  sel_enable_a: assert property (loaded |-> !(o_rc_osc_enable && sel != 2'b10) &&
    !(o_crystal_osc_enable && sel != 2'b11)) else $error("wrong enable");
  main_follow_a: assert property (quiet > 3'h4 |->
    o_main_reference_clock == $past(sel_clk, 3)) else $error("main path");
  pin_xtal_a: assert property (quiet > 3'h4 && sel == 2'b11 |->
    o_osc_output_pin == $past(i_crystal_amp_out, 3)) else $error("pin xtal");
  pin_bus_a: assert property (quiet > 3'h4 && (sel == 2'b01 || sel == 2'b10) |->
    o_osc_output_pin == $past(i_bus_clock, 3)) else $error("pin bus");
  cover property (quiet > 3'h4 && sel == 2'b11);
  cover property (i_stop_mode && o_rc_osc_enable);
  cover property (i_stop_mode && !o_internal_osc_enable);
endmodule
bind ocs_top ocs_checker ocs_checker_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_internal_osc_clock(i_internal_osc_clock), .i_rc_osc_clock(i_rc_osc_clock),
  .i_crystal_osc_clock(i_crystal_osc_clock), .i_crystal_amp_out(i_crystal_amp_out), .i_bus_clock(i_bus_clock),
  .i_mask_option_word(i_mask_option_word), .i_stop_mode(i_stop_mode),
  .o_internal_osc_enable(o_internal_osc_enable), .o_rc_osc_enable(o_rc_osc_enable),
  .o_crystal_osc_enable(o_crystal_osc_enable), .o_main_reference_clock(o_main_reference_clock),
  .o_pll_reference_clock(o_pll_reference_clock), .o_osc_output_pin(o_osc_output_pin)
);
`default_nettype wire

// ===== testbench/ocs_osc_bank.sv
// Behavioural oscillators that feed the clock select block
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_bank (
  input wire logic i_int_en,
  input wire logic i_rc_en,
  input wire logic i_xtal_en,
  output logic o_int,
  output logic o_rc,
  output logic o_xtal,
  output logic o_amp,
  output logic o_bus
);
  // Inverting amplifier stage of the crystal
  assign o_amp = ~o_xtal;
  // Toggles sit half a nanosecond off the clock grid so no change meets a sampling edge;
  // a disabled oscillator halts low
  initial begin
    {o_int, o_rc, o_xtal, o_bus} = 4'h0;
    #0.5;
    fork
      forever #6 o_int = i_int_en ? ~o_int : 1'b0;
      forever #10 o_rc = i_rc_en ? ~o_rc : 1'b0;
      forever #14 o_xtal = i_xtal_en ? ~o_xtal : 1'b0;
      forever #4 o_bus = ~o_bus;
    join
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the oscillator clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk, i_rst, i_stop_mode, i_bus_clock, i_crystal_amp_out;
  logic i_internal_osc_clock, i_rc_osc_clock, i_crystal_osc_clock;
  logic [7:0] i_mask_option_word;
  logic o_internal_osc_enable, o_rc_osc_enable, o_crystal_osc_enable, o_osc_output_pin;
  logic o_main_reference_clock, o_pll_reference_clock, o_timebase_reference_clock;
  logic [17:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid, i_s_axi_bready, i_s_axi_rready;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_arready, o_s_axi_bvalid, o_s_axi_rvalid;
  int errors, total_checks, cycles;
  ocs_top ocs_top_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_internal_osc_clock(i_internal_osc_clock), .i_rc_osc_clock(i_rc_osc_clock),
    .i_crystal_osc_clock(i_crystal_osc_clock), .i_crystal_amp_out(i_crystal_amp_out), .i_bus_clock(i_bus_clock),
    .i_mask_option_word(i_mask_option_word), .i_stop_mode(i_stop_mode),
    .o_internal_osc_enable(o_internal_osc_enable), .o_rc_osc_enable(o_rc_osc_enable),
    .o_crystal_osc_enable(o_crystal_osc_enable), .o_main_reference_clock(o_main_reference_clock),
    .o_pll_reference_clock(o_pll_reference_clock), .o_timebase_reference_clock(o_timebase_reference_clock),
    .o_osc_output_pin(o_osc_output_pin),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready));
  ocs_osc_bank ocs_osc_bank_inst (.i_int_en(o_internal_osc_enable), .i_rc_en(o_rc_osc_enable),
    .i_xtal_en(o_crystal_osc_enable), .o_int(i_internal_osc_clock), .o_rc(i_rc_osc_clock),
    .o_xtal(i_crystal_osc_clock), .o_amp(i_crystal_amp_out), .o_bus(i_bus_clock));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken; ready is low at the exit edge
  task axi_wr(input logic [17:0] a, input logic [31:0] w);
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_awvalid, i_s_axi_wvalid} <= {a, w, 2'b11};
    do begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid);
    r = o_s_axi_bresp;
  endtask
  task axi_rd(input logic [17:0] a);
    {i_s_axi_araddr, i_s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    {d, r} = {o_s_axi_rdata, o_s_axi_rresp};
  endtask
  // Reset value, read-only option word, unmapped place, enable status
  task sc_regs(input logic [1:0] s);
    axi_rd(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO);
    chk(d, 32'(ocs_pkg::OCS_CFG_RESET));
    axi_wr(ocs_pkg::OCS_ADDR_MASK_OPTION_WORD, 32'h0);
    chk(32'(r), 32'(ocs_pkg::OCS_RESP_OKAY));
    axi_rd(ocs_pkg::OCS_ADDR_MASK_OPTION_WORD);
    chk(d, 32'(s));
    axi_rd(18'h00100);
    chk(32'(r), 32'(ocs_pkg::OCS_RESP_SLVERR));
    axi_wr(18'h00100, 32'h0);
    chk(32'(r), 32'(ocs_pkg::OCS_RESP_SLVERR));
    // Low byte lane off: the config write must leave every field alone
    i_s_axi_wstrb <= 4'he;
    axi_wr(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO, 32'h1f);
    i_s_axi_wstrb <= 4'hf;
    axi_rd(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO);
    chk(d, 32'(ocs_pkg::OCS_CFG_RESET));
    axi_rd(ocs_pkg::OCS_ADDR_STATUS);
    chk(d, {29'h0, s == 2'b11, s == 2'b10, 1'b1});
  endtask
  // Every timebase code; RC and crystal pass only when they are also the main source
  task sc_timebase(input logic [1:0] s);
    int t;
    logic last;
    for (int c = 0; c < 4; c++) begin
      axi_wr(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO, 32'(c));
      axi_rd(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO);
      chk(d, 32'(c));
      repeat (4) @(posedge i_clk);
      last = o_timebase_reference_clock;
      t = 0;
      repeat (40) begin
        @(posedge i_clk);
        if (o_timebase_reference_clock !== last) t++;
        last = o_timebase_reference_clock;
      end
      chk(t > 0, c == 0 || (c == 1 && s == 2'b10) || (c == 2 && s == 2'b11));
    end
  endtask
  // Stop with all stop bits clear, then with internal-off and both keep bits set
  task sc_stop(input logic [1:0] s);
    for (int k = 0; k < 2; k++) begin
      axi_wr(ocs_pkg::OCS_ADDR_CONFIG_WORD_TWO, k ? 32'h1c : 32'h0);
      i_stop_mode <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk({o_internal_osc_enable, o_rc_osc_enable, o_crystal_osc_enable},
        {k == 0, k == 1 && s == 2'b10, k == 1 && s == 2'b11});
      i_stop_mode <= 1'b0;
      repeat (8) @(posedge i_clk);
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Whole run needs about 1170 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    {i_rst, i_stop_mode, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = 5'b10000;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_mask_option_word} = '0;
    {i_s_axi_wstrb, i_s_axi_bready, i_s_axi_rready} = 6'h3f;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      {i_rst, i_mask_option_word} <= {1'b1, 8'(s)};
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (40) @(posedge i_clk);
      sc_regs(2'(s));
      // A later change of the option word must not move the selection
      i_mask_option_word <= 8'(3 - s);
      sc_timebase(2'(s));
      sc_stop(2'(s));
    end
    close_out;
  end
endmodule
`default_nettype wire
